// ---- rtl/cfs_params.svh ----
`ifndef CFS_PARAMS_SVH
`define CFS_PARAMS_SVH

// Register word addresses on the plain register port.
`define CFS_ADDR_CTRL 4'h0
`define CFS_ADDR_WMARK 4'h1
`define CFS_ADDR_LIMIT 4'h2
`define CFS_ADDR_CHEN 4'h3
`define CFS_ADDR_STATUS 4'h4
`define CFS_ADDR_ISTAT 4'h5
`define CFS_ADDR_IMASK 4'h6

// Control register fields.
`define CFS_CTRL_EN_BIT 0
`define CFS_CTRL_MODE_BIT 1
`define CFS_CTRL_FLUSH_BIT 2

// Status register fields; the fill count sits above the flags.
`define CFS_ST_EMPTY_BIT 0
`define CFS_ST_FILL_BIT 1
`define CFS_ST_OVERRUN_BIT 2
`define CFS_ST_UNDER_BIT 3
`define CFS_ST_CNT_LSB 8

// Reset values.
`define CFS_FLAGS_RESET 4'h1
`define CFS_WMARK_RESET 9'h001
`define CFS_LIMIT_RESET 12'h000
`define CFS_CHEN_RESET 16'h0000
`define CFS_IMASK_RESET 4'h0

`endif

// ---- rtl/cfs_pkg.sv ----
package cfs_pkg;

  // Queue behaviour when a result meets a full queue.
  typedef enum logic [0:0] {
    CFS_MODE_WMARK = 1'h0,
    CFS_MODE_STREAM = 1'h1
  } cfs_mode_t;

  // Status flags in register bit order, bit 0 last.
  typedef struct packed {
    logic under_limit_hit;
    logic overrun;
    logic fill_level;
    logic empty;
  } cfs_flags_t;

  // One conversion result offered to the queue.
  typedef struct packed {
    logic valid;
    logic [3:0] chan;
    logic [15:0] data;
  } cfs_conv_t;

endpackage

// ---- rtl/cfs_occupancy.sv ----
`timescale 1ns/1ps
// Tracks how many samples the queue holds and decides what a new
// result does when the queue is full.
module cfs_occupancy #(
  parameter int DEPTH = 256,
  parameter int CW = 9
) (
  input wire logic i_sys_clk, // System clock.
  input wire logic i_rst_b, // Asynchronous reset, active low.
  input wire logic i_enable, // Queue enabled, next-cycle value.
  input wire logic i_flush, // Clear command pulse.
  input wire logic i_stream, // High in streaming mode.
  input wire logic i_push, // New result offered.
  input wire logic i_pop, // Host reads one entry.
  output logic [CW-1:0] o_count, // Stored samples.
  output logic [CW-1:0] o_count_nxt, // Count after this edge.
  output logic o_store, // Result written to storage.
  output logic o_drop, // Result discarded, queue kept.
  output logic o_evict // Oldest entry discarded for result.
);

  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic full;
  logic pop_ok;

  // Next count; a flush or a disable empties the queue outright.
  always_comb begin
    full = (count_q == FULL);
    pop_ok = i_pop && (count_q != '0);
    o_store = 1'b0;
    o_drop = 1'b0;
    o_evict = 1'b0;
    count_d = count_q;
    if (!i_enable || i_flush) begin
      count_d = '0;
    end else if (i_push && pop_ok) begin
      o_store = 1'b1;
    end else if (i_push && !full) begin
      o_store = 1'b1;
      count_d = count_q + CW'(1);
    end else if (i_push && i_stream) begin
      o_store = 1'b1;
      o_evict = 1'b1;
    end else if (i_push) begin
      o_drop = 1'b1;
    end else if (pop_ok) begin
      count_d = count_q - CW'(1);
    end
  end

  // Count register.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign o_count = count_q;
  assign o_count_nxt = count_d;

endmodule

// ---- rtl/cfs_irq.sv ----
`timescale 1ns/1ps
`include "cfs_params.svh"
// Sticky interrupt status with write-one-to-clear and a mask.
module cfs_irq #(
  parameter int N = 4
) (
  input wire logic i_sys_clk, // System clock.
  input wire logic i_rst_b, // Asynchronous reset, active low.
  input wire logic [N-1:0] i_event, // One-cycle event pulses.
  input wire logic i_clr_we, // Write to the status register.
  input wire logic i_mask_we, // Write to the mask register.
  input wire logic [N-1:0] i_wdata, // Write data.
  output logic [N-1:0] o_status, // Sticky status.
  output logic [N-1:0] o_mask, // Mask, one enables.
  output logic o_irq // Level interrupt.
);

  logic [N-1:0] stat_q;
  logic [N-1:0] stat_d;
  logic [N-1:0] mask_q;
  logic [N-1:0] mask_d;

  // A new event outranks a clear in the same cycle so none is lost.
  always_comb begin
    stat_d = stat_q;
    if (i_clr_we) begin
      stat_d = stat_q & ~i_wdata;
    end
    stat_d = stat_d | i_event;
    mask_d = i_mask_we ? i_wdata : mask_q;
  end

  // Status and mask registers.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stat_q <= '0;
      mask_q <= N'(`CFS_IMASK_RESET);
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
    end
  end

  assign o_status = stat_q;
  assign o_mask = mask_q;
  assign o_irq = |(stat_q & mask_q);

endmodule

// ---- rtl/cfs_top.sv ----
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
// Function
// - Watermark mode: result on full queue is dropped, overrun bit 2 sets.
// - Streaming mode: full queue evicts oldest, stores new, sets overrun.
// - Overrun clears once the queue is fully emptied.
// - Each flag has its own interrupt line, rising and falling with it.
// - Fill-level flag sets while stored count is at least the watermark; code holds it low while disabled.
// - Fill-level flag clears while stored count is below the watermark.
// - Empty flag, bit 0, is set when enabled and nothing yet stored.
// - Empty flag sets as the last stored entry is read out.
// - Empty flag sets after a successful clear command.
// - Empty flag is one while disabled and resets to one.
// - Empty flag clears while the queue holds any entry.
// - Every flag reads one when triggered, zero otherwise.
// - Enabled channel result at or below lower limit sets under-limit flag; code sets it only for results written to storage, not dropped ones.
`include "cfs_params.svh"
module cfs_top #(
  parameter int DEPTH = 256,
  parameter int CW = 9,
  parameter int NCH = 16
) (
  input wire logic i_sys_clk, // System clock, 250 MHz.
  input wire logic i_rst_b, // Asynchronous reset, active low.
  input wire logic [3:0] i_addr, // Register word address.
  input wire logic [31:0] i_wdata, // Register write data.
  input wire logic i_we, // Register write strobe.
  input wire logic i_re, // Register read strobe.
  output logic [31:0] o_rdata, // Read data, cycle after i_re.
  input wire cfs_pkg::cfs_conv_t i_conv, // New conversion result.
  input wire logic i_pop, // Host reads one queue entry.
  output logic o_store, // Write result into storage.
  output logic o_drop, // Result discarded.
  output logic o_evict, // Oldest entry discarded.
  output logic [CW-1:0] o_count, // Stored samples.
  output cfs_pkg::cfs_flags_t o_flag_irq, // Per-flag interrupts.
  output logic o_irq // Masked sticky interrupt.
);

  // Control state written by software.
  logic en_q;
  logic en_d;
  cfs_pkg::cfs_mode_t mode_q;
  cfs_pkg::cfs_mode_t mode_d;
  logic [CW-1:0] wmark_q;
  logic [CW-1:0] wmark_d;
  logic [11:0] limit_q;
  logic [11:0] limit_d;
  logic [NCH-1:0] chen_q;
  logic [NCH-1:0] chen_d;
  logic flush;

  // Flags, read data and helpers.
  cfs_pkg::cfs_flags_t flags_q;
  cfs_pkg::cfs_flags_t flags_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [CW-1:0] count;
  logic [CW-1:0] count_nxt;
  logic push;
  logic limit_hit;
  logic [3:0] ist;
  logic [3:0] imask;

  // Write decode for a given word address.
  function automatic logic wr_hit(input logic [3:0] a);
    wr_hit = i_we && (i_addr == a);
  endfunction

  // Control registers; the flush bit is a command and is not stored.
  always_comb begin
    en_d = en_q;
    mode_d = mode_q;
    wmark_d = wmark_q;
    limit_d = limit_q;
    chen_d = chen_q;
    flush = 1'b0;
    if (wr_hit(`CFS_ADDR_CTRL)) begin
      en_d = i_wdata[`CFS_CTRL_EN_BIT];
      mode_d = cfs_pkg::cfs_mode_t'(i_wdata[`CFS_CTRL_MODE_BIT]);
      flush = i_wdata[`CFS_CTRL_FLUSH_BIT];
    end else if (wr_hit(`CFS_ADDR_WMARK)) begin
      wmark_d = i_wdata[CW-1:0];
    end else if (wr_hit(`CFS_ADDR_LIMIT)) begin
      limit_d = i_wdata[11:0];
    end else if (wr_hit(`CFS_ADDR_CHEN)) begin
      chen_d = i_wdata[NCH-1:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en_q <= 1'b0;
      mode_q <= cfs_pkg::CFS_MODE_WMARK;
      wmark_q <= CW'(`CFS_WMARK_RESET);
      limit_q <= `CFS_LIMIT_RESET;
      chen_q <= NCH'(`CFS_CHEN_RESET);
    end else begin
      en_q <= en_d;
      mode_q <= mode_d;
      wmark_q <= wmark_d;
      limit_q <= limit_d;
      chen_q <= chen_d;
    end
  end

  // Results are only taken while the queue is already enabled.
  assign push = i_conv.valid && en_q;

  // The occupancy tracker sees the next enable so that disabling
  // empties the count on the same edge as the enable bit falls.
  cfs_occupancy #(
    .DEPTH(DEPTH),
    .CW(CW)
  ) u_occ (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_enable(en_d),
    .i_flush(flush),
    .i_stream(mode_q == cfs_pkg::CFS_MODE_STREAM),
    .i_push(push),
    .i_pop(i_pop),
    .o_count(count),
    .o_count_nxt(count_nxt),
    .o_store(o_store),
    .o_drop(o_drop),
    .o_evict(o_evict)
  );

  // Only the upper twelve bits of a result meet the lower limit, as
  // the limit register is twelve bits wide.
  assign limit_hit = o_store && chen_q[i_conv.chan]
                     && (i_conv.data[15:4] <= limit_q);

  // Flags follow the count that the queue holds after this edge, so
  // they change on the same edge as the count itself.
  always_comb begin
    flags_d.empty = !en_d || (count_nxt == '0);
    flags_d.fill_level = en_d && (count_nxt >= wmark_d);
    flags_d.overrun = (o_drop || o_evict)
                      || (flags_q.overrun && (count_nxt != '0));
    flags_d.under_limit_hit = limit_hit
                      || (flags_q.under_limit_hit && (count_nxt != '0));
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flags_q <= `CFS_FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Each flag drives its own line straight from the flag register.
  assign o_flag_irq = flags_q;
  assign o_count = count;

  // Rising flags latch into the sticky interrupt status.
  cfs_irq #(
    .N(4)
  ) u_irq (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_event(flags_d & ~flags_q),
    .i_clr_we(wr_hit(`CFS_ADDR_ISTAT)),
    .i_mask_we(wr_hit(`CFS_ADDR_IMASK)),
    .i_wdata(i_wdata[3:0]),
    .o_status(ist),
    .o_mask(imask),
    .o_irq(o_irq)
  );

  // Read mux; unmapped addresses and idle cycles return zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (!i_re) begin
      rdata_d = 32'h0000_0000;
    end else if (i_addr == `CFS_ADDR_CTRL) begin
      rdata_d[`CFS_CTRL_EN_BIT] = en_q;
      rdata_d[`CFS_CTRL_MODE_BIT] = mode_q;
    end else if (i_addr == `CFS_ADDR_WMARK) begin
      rdata_d[CW-1:0] = wmark_q;
    end else if (i_addr == `CFS_ADDR_LIMIT) begin
      rdata_d[11:0] = limit_q;
    end else if (i_addr == `CFS_ADDR_CHEN) begin
      rdata_d[NCH-1:0] = chen_q;
    end else if (i_addr == `CFS_ADDR_STATUS) begin
      rdata_d[3:0] = flags_q;
      rdata_d[`CFS_ST_CNT_LSB +: CW] = count;
    end else if (i_addr == `CFS_ADDR_ISTAT) begin
      rdata_d[3:0] = ist;
    end else if (i_addr == `CFS_ADDR_IMASK) begin
      rdata_d[3:0] = imask;
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  // Checks on the flag behaviour.
  property p_drop_overrun;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (push && !i_pop && !flush && en_d && count == CW'(DEPTH)
     && mode_q == cfs_pkg::CFS_MODE_WMARK)
    |-> o_drop && !o_store ##1 flags_q.overrun && count == CW'(DEPTH);
  endproperty
  a_drop_overrun: assert property (p_drop_overrun)
    else $error("Dropped result did not set overrun.");

  property p_evict_overrun;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (push && !i_pop && !flush && en_d && count == CW'(DEPTH)
     && mode_q == cfs_pkg::CFS_MODE_STREAM)
    |-> o_evict && o_store ##1 flags_q.overrun;
  endproperty
  a_evict_overrun: assert property (p_evict_overrun)
    else $error("Streaming overflow did not evict and set overrun.");

  property p_overrun_clear;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (count == '0) |-> !flags_q.overrun && !flags_q.under_limit_hit;
  endproperty
  a_overrun_clear: assert property (p_overrun_clear)
    else $error("Overrun or limit flag set on an empty queue.");

  property p_flag_irq;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    $rose(flags_q.fill_level) |-> $rose(o_flag_irq.fill_level)
      && rdata_d[`CFS_ST_FILL_BIT] == (i_re && i_addr == `CFS_ADDR_STATUS);
  endproperty
  a_flag_irq: assert property (p_flag_irq)
    else $error("Fill-level interrupt not in step with the flag.");

  property p_fill_set;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (en_q && count >= wmark_q) |-> flags_q.fill_level;
  endproperty
  a_fill_set: assert property (p_fill_set)
    else $error("Fill-level flag low at or above watermark.");

  property p_fill_clr;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (count < wmark_q) |-> !flags_q.fill_level;
  endproperty
  a_fill_clr: assert property (p_fill_clr)
    else $error("Fill-level flag high below watermark.");

  property p_empty_level;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    flags_q.empty == (!en_q || count == '0);
  endproperty
  a_empty_level: assert property (p_empty_level)
    else $error("Empty flag does not match the stored count.");

  property p_last_read;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_pop && !push && count == CW'(1)) |=> flags_q.empty;
  endproperty
  a_last_read: assert property (p_last_read)
    else $error("Reading the last entry did not set empty.");

  property p_flush_empty;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    flush |=> flags_q.empty && count == '0 && !flags_q.overrun;
  endproperty
  a_flush_empty: assert property (p_flush_empty)
    else $error("Clear command did not empty the queue.");

  property p_disabled_empty;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    !en_q |-> flags_q.empty && !o_store;
  endproperty
  a_disabled_empty: assert property (p_disabled_empty)
    else $error("Disabled queue not showing empty.");

  property p_nonempty;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (o_store && !flush && en_d) |=> !flags_q.empty;
  endproperty
  a_nonempty: assert property (p_nonempty)
    else $error("Stored entry left the empty flag set.");

  property p_limit_hit;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (o_store && !flush && en_d && chen_q[i_conv.chan]
     && i_conv.data[15:4] <= limit_q) |=> flags_q.under_limit_hit;
  endproperty
  a_limit_hit: assert property (p_limit_hit)
    else $error("Result at or below limit did not set the flag.");

  property p_irq_out;
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    $rose(flags_q.overrun) && imask[`CFS_ST_OVERRUN_BIT] |-> o_irq;
  endproperty
  a_irq_out: assert property (p_irq_out)
    else $error("Unmasked overrun did not raise the interrupt.");

endmodule

// ---- bench/cfs_conv_model.sv ----
`timescale 1ns/1ps
// Converter side of the queue: offers results one at a time, as the
// sequencer would, and reports what the queue did with each one.
module cfs_conv_model (
  input wire logic i_sys_clk, // System clock.
  input wire logic i_store, // Result written into storage.
  input wire logic i_drop, // Result discarded.
  input wire logic i_evict, // Oldest entry discarded.
  output cfs_pkg::cfs_conv_t o_conv // Result offered to the queue.
);
  initial o_conv = '0;

  // Offer one result for one cycle; the outcome pulses are combinational,
  // so they are sampled inside that cycle once the edge has settled.
  task automatic offer(input logic [3:0] ch, input logic [15:0] d,
                       output logic [2:0] seen);
    @(posedge i_sys_clk);
    o_conv <= '{valid: 1'b1, chan: ch, data: d};
    #1;
    seen = {i_store, i_drop, i_evict};
    @(posedge i_sys_clk);
    // Between results the lines carry junk, so a stale value cannot pass.
    o_conv <= '{valid: 1'b0, chan: ~ch, data: ~d};
  endtask
endmodule

// ---- bench/cfs_top_test.sv ----
`timescale 1ns/1ps
`include "cfs_params.svh"
// Drives the register port and queue events and checks the status view.
module cfs_top_test;
  localparam int DEPTH = 8;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_we = 1'b0;
  logic i_re = 1'b0;
  logic i_pop = 1'b0;
  cfs_pkg::cfs_conv_t conv;
  logic [31:0] o_rdata;
  logic o_store;
  logic o_drop;
  logic o_evict;
  logic o_irq;
  logic [3:0] o_count;
  cfs_pkg::cfs_flags_t o_flag_irq;
  int fail_count = 0;
  int checks_done = 0;
  int cnt = 0;
  logic [31:0] rd;

  // A small depth keeps the fill scenarios short.
  cfs_top #(.DEPTH(DEPTH), .CW(4), .NCH(16)) i_dut (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata),
    .i_conv(conv), .i_pop(i_pop), .o_store(o_store), .o_drop(o_drop),
    .o_evict(o_evict), .o_count(o_count), .o_flag_irq(o_flag_irq),
    .o_irq(o_irq)
  );

  cfs_conv_model i_model (
    .i_sys_clk(i_sys_clk), .i_store(o_store), .i_drop(o_drop),
    .i_evict(o_evict), .o_conv(conv)
  );

  // Clock at 250 MHz.
  always #2 i_sys_clk = ~i_sys_clk;

  // Compare one value and count the outcome.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Register write: one cycle with the write strobe high.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_we <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_we <= 1'b0;
  endtask

  // Register read: data stand only in the cycle after the strobe.
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
    @(posedge i_sys_clk);
    i_re <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_re <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  // Status word, count output and per-flag interrupts against the model.
  task automatic st(input logic [3:0] fl);
    rd_reg(`CFS_ADDR_STATUS, rd);
    check(rd, {15'h0000, 9'(cnt), 4'h0, fl});
    check({28'h0, o_count}, 32'(cnt));
    check({28'h0, o_flag_irq}, {28'h0, fl});
  endtask

  // Offer one result and compare {store, drop, evict}.
  task automatic push(input logic [3:0] ch, input logic [15:0] d,
                      input logic [2:0] exp);
    logic [2:0] seen;
    i_model.offer(ch, d, seen);
    check({29'h0, seen}, {29'h0, exp});
    if (exp == 3'b100) cnt++;
  endtask

  // Host reads one entry.
  task automatic pop;
    @(posedge i_sys_clk);
    i_pop <= 1'b1;
    @(posedge i_sys_clk);
    i_pop <= 1'b0;
    cnt--;
  endtask

  // Single place where the run ends.
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    fail_count++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    st(4'h1);
    check({31'h0, o_irq}, 32'h0);
    rd_reg(4'hF, rd);
    check(rd, 32'h0);
    wr(`CFS_ADDR_WMARK, 32'h3);
    wr(`CFS_ADDR_CTRL, 32'h1);
    rd_reg(`CFS_ADDR_WMARK, rd);
    check(rd, 32'h3);
    st(4'h1);
    push(4'h0, 16'hFFF0, 3'b100);
    st(4'h0);
    push(4'h0, 16'hFFF0, 3'b100);
    push(4'h0, 16'hFFF0, 3'b100);
    st(4'h2);
    pop();
    st(4'h0);
    // Overrun in watermark mode, with only overrun unmasked.
    wr(`CFS_ADDR_ISTAT, 32'hF);
    wr(`CFS_ADDR_IMASK, 32'h4);
    rd_reg(`CFS_ADDR_IMASK, rd);
    check(rd, 32'h4);
    while (cnt < DEPTH) push(4'h0, 16'hFFF0, 3'b100);
    push(4'h0, 16'hFFF0, 3'b010);
    st(4'h6);
    check({31'h0, o_irq}, 32'h1);
    rd_reg(`CFS_ADDR_ISTAT, rd);
    check(rd & 32'h4, 32'h4);
    wr(`CFS_ADDR_ISTAT, 32'h4);
    #1;
    check({31'h0, o_irq}, 32'h0);
    while (cnt > 1) pop();
    st(4'h4);
    pop();
    st(4'h1);
    // Streaming mode: a full queue evicts its oldest entry.
    wr(`CFS_ADDR_CTRL, 32'h3);
    while (cnt < DEPTH) push(4'h0, 16'hFFF0, 3'b100);
    push(4'h0, 16'hFFF0, 3'b101);
    st(4'h6);
    wr(`CFS_ADDR_CTRL, 32'h7);
    // The clear command is a strobe and must read back as zero.
    rd_reg(`CFS_ADDR_CTRL, rd);
    check(rd, 32'h3);
    cnt = 0;
    st(4'h1);
    // Lower limit on channel 2 only.
    wr(`CFS_ADDR_LIMIT, 32'h10);
    wr(`CFS_ADDR_CHEN, 32'h4);
    rd_reg(`CFS_ADDR_LIMIT, rd);
    check(rd, 32'h10);
    rd_reg(`CFS_ADDR_CHEN, rd);
    check(rd, 32'h4);
    push(4'h1, 16'h0000, 3'b100);
    st(4'h0);
    push(4'h2, 16'h0110, 3'b100);
    st(4'h0);
    push(4'h2, 16'h0100, 3'b100);
    st(4'hA);
    wr(`CFS_ADDR_CTRL, 32'h0);
    cnt = 0;
    st(4'h1);
    report_and_stop();
  end
endmodule
